// *** flash_rst_cfg.svh ***
// Timing, code and field constants shared by both ends of the flash reset link.
`ifndef FLASH_RST_CFG_SVH
`define FLASH_RST_CFG_SVH
`define FRC_CLK_NS          25
`define FRC_RST_LOW_MIN_NS  100
`define FRC_SUPPLY_REL_US   300
`define FRC_REL_READ_NS     150
`define FRC_REL_WRITE_NS    150
`define FRC_BUSY_CYCLES     8
`define FRC_APS_IDLE_CYCLES 4
`define FRC_RD_CYCLES       3
`define FRC_WORD_W          16
`define FRC_STATUS_RESET    16'h0080
`define FRC_SR_READY        7
`define FRC_SR_ERASE_ERR    5
`define FRC_SR_PROG_ERR     4
`define FRC_ERASED_WORD     16'hffff
`define FRC_INVALID_WORD    16'h0bad
`define FRC_CMD_READ_ARRAY  16'h00ff
`define FRC_CMD_READ_STATUS 16'h0070
`define FRC_CMD_CLR_STATUS  16'h0050
`define FRC_CMD_PROGRAM     16'h0040
`define FRC_CMD_ERASE       16'h0020
`define FRC_CMD_CONFIRM     16'h00d0
`endif

// *** flash_rst_pkg.sv ***
// Mode and state types for the flash device end and the host end.
package flash_rst_pkg;
    typedef enum logic [5:0] {
        DEV_RESET       = 6'h01,
        DEV_READ_ARRAY  = 6'h02,
        DEV_READ_STATUS = 6'h04,
        DEV_PROG_SETUP  = 6'h08,
        DEV_ERASE_SETUP = 6'h10,
        DEV_BUSY        = 6'h20
    } dev_mode_e;
    typedef enum logic [4:0] {
        H_RST  = 5'h01,
        H_WAIT = 5'h02,
        H_IDLE = 5'h04,
        H_WR   = 5'h08,
        H_RD   = 5'h10
    } host_state_e;
endpackage

// *** flash_link_if.sv ***
// Pin-level link between the flash device end and its host.
`timescale 1ns/1ps
interface flash_link_if #(parameter int AW = 4) (input wire logic clock);
    logic          rst_n;
    logic          host_pin_oe;
    logic          host_ce_n;
    logic          host_oe_n;
    logic          host_we_n;
    logic [AW-1:0] host_addr;
    logic [15:0]   host_dq_o;
    logic          host_dq_oe;
    logic [15:0]   dev_dq_o;
    logic          dev_dq_oe;
    logic          dev_wait_o;
    logic          dev_wait_oe;
    logic          ce_n;
    logic          oe_n;
    logic          we_n;
    logic [AW-1:0] addr;
    logic [15:0]   dq;
    logic          wait_sig;

    // Undriven control pins idle high, as with board pull-ups.
    assign ce_n     = host_pin_oe ? host_ce_n : 1'b1;
    assign oe_n     = host_pin_oe ? host_oe_n : 1'b1;
    assign we_n     = host_pin_oe ? host_we_n : 1'b1;
    assign addr     = host_pin_oe ? host_addr : '0;
    assign dq       = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : 16'hffff);
    assign wait_sig = dev_wait_oe ? dev_wait_o : 1'b1;

    modport device (input rst_n, ce_n, oe_n, we_n, addr, dq,
                    output dev_dq_o, dev_dq_oe, dev_wait_o, dev_wait_oe);
    modport host (input dq, wait_sig,
                  output rst_n, host_pin_oe, host_ce_n, host_oe_n, host_we_n, host_addr,
                  host_dq_o, host_dq_oe);
endinterface

// *** flash_reset_power_control.sv ***
// Flash device end: reset pin handling, mode control, small array and power saving.
`timescale 1ns/1ps
`include "flash_rst_cfg.svh"
module flash_reset_power_control #(
    parameter int AW    = 4,
    parameter int DEPTH = 16
) (
    input  wire logic               clock,
    input  wire logic               arst_n,
    flash_link_if.device            link,
    output logic                    standby,
    output logic                    in_reset,
    output logic                    busy,
    output flash_rst_pkg::dev_mode_e mode
);
    import flash_rst_pkg::*;

    localparam int WW = `FRC_WORD_W;

    typedef struct packed {
        logic                    sync1;
        logic                    sync2;
        dev_mode_e               mode;
        logic [DEPTH-1:0][WW-1:0] mem;
        logic [WW-1:0]           status;
        logic                    we_prev;
        logic [AW-1:0]           addr_prev;
        logic [AW-1:0]           op_addr;
        logic [WW-1:0]           op_data;
        logic                    op_erase;
        logic [7:0]              busy_cnt;
        logic [WW-1:0]           dq_ff;
        logic                    dq_oe_ff;
        logic                    rd_seen;
        logic [7:0]              idle_cnt;
        logic                    standby;
    } dev_state_s;

    localparam dev_state_s RESET_VAL = '{
        mode:    DEV_RESET,
        mem:     {DEPTH{`FRC_ERASED_WORD}},
        status:  `FRC_STATUS_RESET,
        we_prev: 1'b1,
        default: '0
    };

    dev_state_s s_ff;
    dev_state_s nxt_s;
    logic       wr_edge;
    logic       rd_act;

    //--------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------
    always_comb begin
        nxt_s           = s_ff;
        nxt_s.sync1     = link.rst_n;
        nxt_s.sync2     = s_ff.sync1;
        nxt_s.we_prev   = link.we_n;
        nxt_s.addr_prev = link.addr;
        nxt_s.dq_oe_ff  = 1'b0;
        // A write is taken on the rising edge of the write strobe with the chip selected.
        wr_edge = ~s_ff.we_prev & link.we_n & ~link.ce_n;
        rd_act  = ~link.ce_n & ~link.oe_n;
        if (!s_ff.sync2) begin
            // Two-flop sync plus one cycle lands inside the minimum low time.
            if (s_ff.mode == DEV_BUSY) begin
                nxt_s.mem[s_ff.op_addr] = `FRC_INVALID_WORD;
            end
            nxt_s.mode     = DEV_RESET;
            nxt_s.standby  = 1'b0;
            nxt_s.rd_seen  = 1'b0;
            nxt_s.idle_cnt = '0;
        end else begin
            case (s_ff.mode)
                DEV_RESET: begin
                    nxt_s.mode   = DEV_READ_ARRAY;
                    nxt_s.status = `FRC_STATUS_RESET;
                end
                DEV_READ_ARRAY, DEV_READ_STATUS: begin
                    if (wr_edge) begin
                        case (link.dq)
                            `FRC_CMD_READ_ARRAY:  nxt_s.mode = DEV_READ_ARRAY;
                            `FRC_CMD_READ_STATUS: nxt_s.mode = DEV_READ_STATUS;
                            `FRC_CMD_PROGRAM:     nxt_s.mode = DEV_PROG_SETUP;
                            `FRC_CMD_ERASE:       nxt_s.mode = DEV_ERASE_SETUP;
                            `FRC_CMD_CLR_STATUS: begin
                                nxt_s.status[`FRC_SR_PROG_ERR]  = 1'b0;
                                nxt_s.status[`FRC_SR_ERASE_ERR] = 1'b0;
                            end
                            default: nxt_s.mode = s_ff.mode;
                        endcase
                    end
                end
                DEV_PROG_SETUP: begin
                    if (wr_edge) begin
                        nxt_s.op_addr                = link.addr;
                        nxt_s.op_data                = link.dq;
                        nxt_s.op_erase               = 1'b0;
                        nxt_s.busy_cnt               = '0;
                        nxt_s.status[`FRC_SR_READY]  = 1'b0;
                        nxt_s.mode                   = DEV_BUSY;
                    end
                end
                DEV_ERASE_SETUP: begin
                    if (wr_edge) begin
                        if (link.dq == `FRC_CMD_CONFIRM) begin
                            nxt_s.op_addr               = '0;
                            nxt_s.op_erase              = 1'b1;
                            nxt_s.status[`FRC_SR_READY] = 1'b0;
                            nxt_s.mode                  = DEV_BUSY;
                        end else begin
                            // A bad confirm flags a command sequence error.
                            nxt_s.status[`FRC_SR_PROG_ERR]  = 1'b1;
                            nxt_s.status[`FRC_SR_ERASE_ERR] = 1'b1;
                            nxt_s.mode                      = DEV_READ_STATUS;
                        end
                    end
                end
                DEV_BUSY: begin
                    if (s_ff.op_erase) begin
                        // Erase walks the array one word per cycle, so an abort spoils one word.
                        nxt_s.mem[s_ff.op_addr] = `FRC_ERASED_WORD;
                        nxt_s.op_addr           = AW'(s_ff.op_addr + 1'b1);
                        if (s_ff.op_addr == AW'(DEPTH - 1)) begin
                            nxt_s.status[`FRC_SR_READY] = 1'b1;
                            nxt_s.mode                  = DEV_READ_STATUS;
                        end
                    end else if (s_ff.busy_cnt == 8'(`FRC_BUSY_CYCLES - 1)) begin
                        // Programming can only clear bits.
                        nxt_s.mem[s_ff.op_addr]     = s_ff.mem[s_ff.op_addr] & s_ff.op_data;
                        nxt_s.status[`FRC_SR_READY] = 1'b1;
                        nxt_s.mode                  = DEV_READ_STATUS;
                    end else begin
                        nxt_s.busy_cnt = 8'(s_ff.busy_cnt + 1'b1);
                    end
                end
                default: nxt_s.mode = DEV_RESET;
            endcase

            //------------------------------------------------------------
            // Read data and automatic power saving
            //------------------------------------------------------------
            if (rd_act) begin
                nxt_s.dq_oe_ff = 1'b1;
                nxt_s.dq_ff    = (s_ff.mode == DEV_READ_ARRAY) ? s_ff.mem[link.addr]
                                                               : s_ff.status;
                nxt_s.rd_seen  = 1'b1;
                nxt_s.idle_cnt = '0;
                nxt_s.standby  = 1'b0;
            end else if (!link.ce_n || link.addr != s_ff.addr_prev) begin
                nxt_s.idle_cnt = '0;
                nxt_s.standby  = 1'b0;
            end else if (s_ff.rd_seen && !s_ff.standby) begin
                if (s_ff.idle_cnt == 8'(`FRC_APS_IDLE_CYCLES - 1)) begin
                    nxt_s.standby = 1'b1;
                end else begin
                    nxt_s.idle_cnt = 8'(s_ff.idle_cnt + 1'b1);
                end
            end
        end
    end

    //--------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= RESET_VAL;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs follow the registered enable, which reset forces low.
    assign link.dev_dq_o    = s_ff.dq_ff;
    assign link.dev_dq_oe   = s_ff.dq_oe_ff;
    assign link.dev_wait_o  = 1'b0;
    assign link.dev_wait_oe = s_ff.dq_oe_ff;
    assign standby          = s_ff.standby;
    assign in_reset         = (s_ff.mode == DEV_RESET);
    assign busy             = (s_ff.mode == DEV_BUSY);
    assign mode             = s_ff.mode;
endmodule

// *** flash_host_ctrl.sv ***
// Host end: power-aware reset sequencing and single-word flash bus cycles.
`timescale 1ns/1ps
`include "flash_rst_cfg.svh"
module flash_host_ctrl #(
    parameter int AW             = 4,
    parameter int SUPPLY_REL_CYC = (`FRC_SUPPLY_REL_US * 1000) / `FRC_CLK_NS
) (
    input  wire logic          clock,
    input  wire logic          arst_n,
    flash_link_if.host         link,
    input  wire logic          power_good,
    input  wire logic          cpu_rst_n,
    input  wire logic          req_valid,
    input  wire logic          req_write,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [15:0]   req_wdata,
    output logic               req_ready,
    output logic               rsp_valid,
    output logic [15:0]        rsp_data,
    output logic               flash_ready
);
    import flash_rst_pkg::*;

    localparam int RST_LOW_CYC   = (`FRC_RST_LOW_MIN_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS;
    localparam int REL_READ_CYC  = (`FRC_REL_READ_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS;
    localparam int REL_WRITE_CYC = (`FRC_REL_WRITE_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS;
    localparam int POST_CYC      = (REL_READ_CYC > REL_WRITE_CYC) ? REL_READ_CYC : REL_WRITE_CYC;
    // Sized for all counts together, so a short supply delay cannot clip the others.
    localparam int CW            = $clog2(SUPPLY_REL_CYC + RST_LOW_CYC + POST_CYC + 2);

    typedef struct packed {
        host_state_e   state;
        logic [CW-1:0] pwr_cnt;
        logic [CW-1:0] cnt;
        logic          rst_n_ff;
        logic          pin_oe;
        logic          ce_n;
        logic          oe_n;
        logic          we_n;
        logic [AW-1:0] addr;
        logic [15:0]   dq;
        logic          dq_oe;
        logic          rsp_valid;
        logic [15:0]   rsp_data;
    } host_state_s;

    localparam host_state_s RESET_VAL = '{
        state: H_RST, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0
    };

    host_state_s s_ff;
    host_state_s nxt_s;

    //--------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------
    always_comb begin
        nxt_s           = s_ff;
        nxt_s.rsp_valid = 1'b0;
        nxt_s.pin_oe    = power_good;
        if (!power_good) begin
            nxt_s.pwr_cnt = '0;
        end else if (s_ff.pwr_cnt != CW'(SUPPLY_REL_CYC)) begin
            nxt_s.pwr_cnt = CW'(s_ff.pwr_cnt + 1'b1);
        end
        if (!power_good || !cpu_rst_n) begin
            // Any supply loss or processor reset pulls the flash into reset at once.
            nxt_s.state    = H_RST;
            nxt_s.rst_n_ff = 1'b0;
            nxt_s.ce_n     = 1'b1;
            nxt_s.oe_n     = 1'b1;
            nxt_s.we_n     = 1'b1;
            nxt_s.dq_oe    = 1'b0;
            if (s_ff.state != H_RST) begin
                nxt_s.cnt = '0;
            end else if (s_ff.cnt != CW'(RST_LOW_CYC)) begin
                nxt_s.cnt = CW'(s_ff.cnt + 1'b1);
            end
        end else begin
            case (s_ff.state)
                H_RST: begin
                    if (s_ff.cnt != CW'(RST_LOW_CYC)) begin
                        nxt_s.cnt = CW'(s_ff.cnt + 1'b1);
                    end else if (s_ff.pwr_cnt == CW'(SUPPLY_REL_CYC)) begin
                        nxt_s.rst_n_ff = 1'b1;
                        nxt_s.cnt      = '0;
                        nxt_s.state    = H_WAIT;
                    end
                end
                H_WAIT: begin
                    if (s_ff.cnt == CW'(POST_CYC - 1)) begin
                        nxt_s.state = H_IDLE;
                    end else begin
                        nxt_s.cnt = CW'(s_ff.cnt + 1'b1);
                    end
                end
                H_IDLE: begin
                    if (req_valid) begin
                        nxt_s.ce_n  = 1'b0;
                        nxt_s.addr  = req_addr;
                        nxt_s.cnt   = '0;
                        nxt_s.we_n  = ~req_write;
                        nxt_s.oe_n  = req_write;
                        nxt_s.dq    = req_wdata;
                        nxt_s.dq_oe = req_write;
                        nxt_s.state = req_write ? H_WR : H_RD;
                    end
                end
                H_WR: begin
                    // Strobe low one cycle, then high with data held so the edge is clean.
                    if (!s_ff.we_n) begin
                        nxt_s.we_n = 1'b1;
                    end else begin
                        nxt_s.ce_n  = 1'b1;
                        nxt_s.dq_oe = 1'b0;
                        nxt_s.state = H_IDLE;
                    end
                end
                H_RD: begin
                    if (s_ff.cnt == CW'(`FRC_RD_CYCLES - 1)) begin
                        nxt_s.rsp_data  = link.dq;
                        nxt_s.rsp_valid = 1'b1;
                        nxt_s.ce_n      = 1'b1;
                        nxt_s.oe_n      = 1'b1;
                        nxt_s.state     = H_IDLE;
                    end else begin
                        nxt_s.cnt = CW'(s_ff.cnt + 1'b1);
                    end
                end
                default: nxt_s.state = H_RST;
            endcase
        end
    end

    //--------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= RESET_VAL;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign link.rst_n       = s_ff.rst_n_ff;
    assign link.host_pin_oe = s_ff.pin_oe;
    assign link.host_ce_n   = s_ff.ce_n;
    assign link.host_oe_n   = s_ff.oe_n;
    assign link.host_we_n   = s_ff.we_n;
    assign link.host_addr   = s_ff.addr;
    assign link.host_dq_o   = s_ff.dq;
    assign link.host_dq_oe  = s_ff.dq_oe;
    assign req_ready        = (s_ff.state == H_IDLE);
    assign rsp_valid        = s_ff.rsp_valid;
    assign rsp_data         = s_ff.rsp_data;
    assign flash_ready      = (s_ff.state == H_IDLE) || (s_ff.state == H_WR)
                              || (s_ff.state == H_RD);
endmodule

// *** flash_link_sva.sv ***
// Concurrent checks on the pin link between the flash host end and the device end.
`timescale 1ns/1ps
module flash_link_sva (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic rst_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic host_pin_oe,
    input wire logic host_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic dev_wait_o,
    input wire logic dev_wait_oe
);
    default clocking main_cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // Bus cycle shapes
    // ------------------------------------------------------------
    sequence wr_pulse;
        (!ce_n && host_dq_oe) ##1 we_n ##1 ce_n;
    endsequence

    // Eight settled cycles keep the device's reset synchroniser out of the picture.
    sequence rd_start;
        rst_n[*8] ##1 (!ce_n && !oe_n);
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_reset_floats_outputs: assert property (!rst_n[*4] |-> !dev_dq_oe && !dev_wait_oe)
        else $error("device drives the link while reset is held");
    a_wait_pin_quiet: assert property (dev_wait_oe |-> !dev_wait_o && dev_dq_oe)
        else $error("wait pin driven outside a read");
    a_read_gets_data: assert property (rd_start |=> dev_dq_oe)
        else $error("device did not answer a read one cycle later");
    a_read_drive_ends: assert property (ce_n[*2] |-> !dev_dq_oe)
        else $error("device still drives data after the read ended");
    a_no_bus_clash: assert property (!(dev_dq_oe && host_dq_oe))
        else $error("both ends drive the data bus");
    a_write_strobe_shape: assert property ($fell(we_n) |-> wr_pulse)
        else $error("write strobe cycle malformed");
    a_reset_min_width: assert property ($fell(rst_n) |-> !rst_n[*4])
        else $error("flash reset pulse shorter than four cycles");
    a_release_bus_gap: assert property ($rose(rst_n) |-> ce_n[*6])
        else $error("bus cycle started too soon after reset release");
    a_host_quiet_reset: assert property (!rst_n[*2] |-> ce_n && !host_dq_oe)
        else $error("host runs a bus cycle while flash reset is held");

    c_read_seen: cover property (rd_start);
    c_write_seen: cover property ($fell(we_n) ##0 wr_pulse);
endmodule

// *** testbench.sv ***
// Self-checking bench: host end and device end joined by the flash link.
`timescale 1ns/1ps
`include "flash_rst_cfg.svh"

`define CHECK(what, exp, got) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
end

`define WAIT_UNTIL(cond, lim, what) begin \
    wait_n = 0; \
    while (!(cond) && wait_n < lim) begin \
        @(negedge clock); \
        wait_n++; \
    end \
    if (!(cond)) begin \
        bad_count++; \
        $display("CHECK FAILED %s expected %h seen %h", what, 1'b1, 1'b0); \
        give_verdict(); \
    end \
end

module testbench;
    import flash_rst_pkg::*;
    // A short supply-valid count keeps the run brief; the real one is 12000 cycles.
    localparam int VCC_CYC = 20;
    localparam logic [15:0] STATUS_ERR = `FRC_STATUS_RESET
        | 16'(1 << `FRC_SR_ERASE_ERR) | 16'(1 << `FRC_SR_PROG_ERR);

    logic        clock;
    logic        arst_n;
    logic        power_good;
    logic        cpu_rst_n;
    logic        req_valid;
    logic        req_write;
    logic [3:0]  req_addr;
    logic [15:0] req_wdata;
    logic        req_ready;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        flash_ready;
    logic        standby;
    logic        in_reset;
    logic        busy;
    dev_mode_e   mode;
    logic [15:0] rdata;
    int          wait_n;
    int          bad_count;
    int          cmp_count;

    // ------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------
    flash_link_if #(.AW(4)) link (.clock(clock));

    flash_host_ctrl #(.AW(4), .SUPPLY_REL_CYC(VCC_CYC)) i_flash_host_ctrl (
        .clock(clock), .arst_n(arst_n), .link(link), .power_good(power_good),
        .cpu_rst_n(cpu_rst_n), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .flash_ready(flash_ready));

    flash_reset_power_control #(.AW(4), .DEPTH(16)) i_flash_reset_power_control (
        .clock(clock), .arst_n(arst_n), .link(link), .standby(standby),
        .in_reset(in_reset), .busy(busy), .mode(mode));

    flash_link_sva i_flash_link_sva (
        .clock(clock), .arst_n(arst_n), .rst_n(link.rst_n), .ce_n(link.ce_n),
        .oe_n(link.oe_n), .we_n(link.we_n), .host_pin_oe(link.host_pin_oe),
        .host_dq_oe(link.host_dq_oe), .dev_dq_oe(link.dev_dq_oe),
        .dev_wait_o(link.dev_wait_o), .dev_wait_oe(link.dev_wait_oe));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The request is held until the edge at which ready is seen high.
    task automatic host_cycle(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr  <= a;
        req_wdata <= d;
        @(negedge clock);
        `WAIT_UNTIL(req_ready === 1'b1, 100, "request accepted")
        @(posedge clock);
        req_valid <= 1'b0;
    endtask

    task automatic host_read(input logic [3:0] a, output logic [15:0] d);
        host_cycle(1'b0, a, 16'h0000);
        `WAIT_UNTIL(rsp_valid === 1'b1, 20, "read answer")
        d = rsp_data;
    endtask

    task automatic pulse_cpu_reset();
        @(posedge clock);
        cpu_rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        cpu_rst_n <= 1'b1;
        `WAIT_UNTIL(flash_ready === 1'b1, 300, "host ready again")
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        bad_count++;
        $display("CHECK FAILED %s expected %h seen %h", "run length", 1'b0, 1'b1);
        give_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        power_good = 1'b0;
        cpu_rst_n = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 4'h0;
        req_wdata = 16'h0000;
        bad_count = 0;
        cmp_count = 0;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(negedge clock);
        `CHECK("host pins before supply", 1'b0, link.host_pin_oe)
        `CHECK("flash reset before supply", 1'b0, link.rst_n)
        @(posedge clock);
        power_good <= 1'b1;
        `WAIT_UNTIL(link.rst_n === 1'b1, 200, "reset release")
        `CHECK("supply to release delay", 1'b1, wait_n >= VCC_CYC)
        `WAIT_UNTIL(flash_ready === 1'b1, 50, "host ready")
        `CHECK("mode after release", DEV_READ_ARRAY, mode)
        `CHECK("reset flag after release", 1'b0, in_reset)
        $display("test power_up done");

        host_cycle(1'b1, 4'h0, `FRC_CMD_READ_STATUS);
        host_read(4'h0, rdata);
        `CHECK("status after release", `FRC_STATUS_RESET, rdata)
        host_cycle(1'b1, 4'h0, `FRC_CMD_READ_ARRAY);
        host_read(4'h3, rdata);
        `CHECK("erased word", `FRC_ERASED_WORD, rdata)
        `CHECK("standby during read", 1'b0, standby)
        repeat (6) @(negedge clock);
        `CHECK("standby after quiet read", 1'b1, standby)
        $display("test status_and_standby done");

        host_cycle(1'b1, 4'h0, `FRC_CMD_PROGRAM);
        host_cycle(1'b1, 4'h2, 16'h1234);
        `WAIT_UNTIL(busy === 1'b1, 20, "program start")
        `WAIT_UNTIL(busy === 1'b0, 40, "program end")
        host_cycle(1'b1, 4'h0, `FRC_CMD_READ_ARRAY);
        host_read(4'h2, rdata);
        `CHECK("programmed word", 16'h1234, rdata)
        `CHECK("standby cleared by read", 1'b0, standby)
        $display("test program done");

        host_cycle(1'b1, 4'h0, `FRC_CMD_PROGRAM);
        host_cycle(1'b1, 4'h5, 16'h0000);
        `WAIT_UNTIL(busy === 1'b1, 20, "program start before abort")
        @(posedge clock);
        cpu_rst_n <= 1'b0;
        `WAIT_UNTIL(in_reset === 1'b1, 8, "abort into reset")
        `CHECK("busy after abort", 1'b0, busy)
        repeat (4) @(posedge clock);
        cpu_rst_n <= 1'b1;
        `WAIT_UNTIL(flash_ready === 1'b1, 300, "host ready after abort")
        host_read(4'h5, rdata);
        `CHECK("aborted word", `FRC_INVALID_WORD, rdata)
        host_cycle(1'b1, 4'h0, `FRC_CMD_READ_STATUS);
        host_read(4'h0, rdata);
        `CHECK("status after abort", `FRC_STATUS_RESET, rdata)
        $display("test abort done");

        host_cycle(1'b1, 4'h0, `FRC_CMD_ERASE);
        host_cycle(1'b1, 4'h0, `FRC_CMD_READ_ARRAY);
        host_read(4'h0, rdata);
        `CHECK("status after bad confirm", STATUS_ERR, rdata)

        @(posedge clock);
        cpu_rst_n <= 1'b0;
        `WAIT_UNTIL(link.rst_n === 1'b0, 10, "idle reset on link")
        repeat (3) @(negedge clock);
        `CHECK("idle reset complete", 1'b1, in_reset)
        `CHECK("data pins floated", 1'b0, link.dev_dq_oe)
        @(posedge clock);
        cpu_rst_n <= 1'b1;
        `WAIT_UNTIL(flash_ready === 1'b1, 300, "host ready after idle reset")
        `CHECK("mode after idle reset", DEV_READ_ARRAY, mode)
        host_cycle(1'b1, 4'h0, `FRC_CMD_READ_STATUS);
        host_read(4'h0, rdata);
        `CHECK("status after idle reset", `FRC_STATUS_RESET, rdata)
        $display("test idle_reset done");

        host_cycle(1'b1, 4'h0, `FRC_CMD_ERASE);
        host_cycle(1'b1, 4'h0, `FRC_CMD_CONFIRM);
        `WAIT_UNTIL(busy === 1'b1, 20, "erase start")
        `WAIT_UNTIL(busy === 1'b0, 60, "erase end")
        host_cycle(1'b1, 4'h0, `FRC_CMD_READ_ARRAY);
        host_read(4'h5, rdata);
        `CHECK("word after erase", `FRC_ERASED_WORD, rdata)
        $display("test erase done");

        @(posedge clock);
        power_good <= 1'b0;
        `WAIT_UNTIL(link.rst_n === 1'b0, 10, "reset on supply loss")
        repeat (2) @(negedge clock);
        `CHECK("host pins on supply loss", 1'b0, link.host_pin_oe)
        `CHECK("host not ready on supply loss", 1'b0, flash_ready)
        $display("test power_down done");
        give_verdict();
    end
endmodule
